// ### core/front_panel_defs.svh
/*
 * Timing counts, register offsets and field positions of the front panel block.
 * Assumes a 25 MHz system clock; included by the package and by the block.
 */
`ifndef FRONT_PANEL_DEFS_SVH
`define FRONT_PANEL_DEFS_SVH

// ==========================================================================
// clock and times
`define FP_CLK_HZ 25000000
`define FP_DEBOUNCE_MS 10
`define FP_DEBOUNCE_CYC (`FP_CLK_HZ / 1000 * `FP_DEBOUNCE_MS)
`define FP_POWER_HOLD_S 2
`define FP_POWER_HOLD_CYC (`FP_CLK_HZ * `FP_POWER_HOLD_S)
`define FP_LONG_PRESS_S 3
`define FP_LONG_PRESS_CYC (`FP_CLK_HZ * `FP_LONG_PRESS_S)
`define FP_IDLE_MIN 10
`define FP_IDLE_CYC (64'd25000000 * 64'd60 * `FP_IDLE_MIN)
`define FP_BLINK_MS 250
`define FP_BLINK_CYC (`FP_CLK_HZ / 1000 * `FP_BLINK_MS)

// ==========================================================================
// counter widths
`define FP_DB_W 20
`define FP_PRESS_W 28
`define FP_IDLE_W 36
`define FP_BLINK_W 24
`define FP_STRETCH_MAX 2'h3
`define FP_SLOTS 5

// ==========================================================================
// register map
`define FP_ADR_CTRL 4'h0
`define FP_ADR_CMD 4'h4
`define FP_ADR_STAT 4'h8
`define FP_CTRL_TRIG_LSB 0
`define FP_CTRL_AUTO_BIT 2
`define FP_CTRL_ERR_LSB 4
`define FP_CMD_OFF_BIT 0
`define FP_CMD_NOWAKE_BIT 1
`define FP_TRIG_DEFAULT 2'h0
`define FP_TRIG_WAKE_ONLY 2'h1
`define FP_TRIG_EJECT 2'h2

`endif

// ### core/front_panel_pkg.sv
/*
 * Types of the front panel block: power states and the packed state record.
 * Assumes front_panel_defs.svh on the include path.
 */
`include "front_panel_defs.svh"

package front_panel_pkg;

  // ========================================================================
  // types
  typedef enum logic [3:0] {
    PwrOn = 4'h1,
    PwrSleep = 4'h2,
    PwrOff = 4'h4,
    PwrOffNoWake = 4'h8
  } pwr_type;

  typedef struct packed {
    logic [4:0] sync1;
    logic [4:0] sync2;
    logic [3:0] db;
    logic [3:0] dbPrev;
    logic [3:0][`FP_DB_W-1:0] dbCnt;
    logic [2:0][`FP_PRESS_W-1:0] pressCnt;
    pwr_type pwr;
    logic pwrArmed;
    logic trigInRec;
    logic [`FP_IDLE_W-1:0] idleCnt;
    logic [`FP_BLINK_W-1:0] blinkCnt;
    logic blink;
    logic [3:0] pattern;
    logic [7:0][1:0] stretch;
    logic [1:0] trigMode;
    logic autoOffEn;
    logic [2:0] errCode;
    logic ack;
    logic [31:0] rdData;
    logic startRec;
    logic stopRec;
    logic mark;
    logic factoryReset;
    logic usbEject;
    logic toExternal;
    logic [`FP_SLOTS-1:0] slotLed;
    logic connectLed;
    logic loggingLed;
    logic intLed;
    logic extRedLed;
    logic extGreenLed;
    logic infoLed;
    logic serviceLed;
    logic usbLed;
    logic auxLed;
  } fp_state_type;

endpackage

// ### core/front_panel_control.sv
/*
 * Front panel control: buttons, trigger and wake inputs, power state,
 * recording requests and status indicators, with a classic Wishbone slave.
 * Assumes pins arrive asynchronously and system status inputs on clk.
 */
// What this block does
// - power press while on enters sleep
// - power plus trigger switches fully off
// - no power-button shutdown while host connected
// - host shutdown: ordinary or without wake
// - trigger action state-dependent and host configurable
// - short trigger press while recording marks event
// - trigger held three seconds stops recording
// - default held three seconds restores defaults
// - slot indicator steady if active, flashes traffic
// - connect indicator lit while host connected
// - logging indicator lit, flashes while stopping
// - internal storage indicator flashes on access
// - external indicator red locked, green unlocked
// - service indicator steady, flashes error codes
// - aux indicator steady if active, flashes traffic
// - usb indicator flashes on drive access
// - info indicator flashes during diagnostic file
// - disk recordings go to detected external unit
// - trigger input acts as trigger button
// - wake input rising edge leaves sleep
// - power held two seconds sleeps, stops recording
// - auto sleep after ten idle minutes
`timescale 1ns/1ps
`include "front_panel_defs.svh"

module front_panel_control import front_panel_pkg::*; #(
  parameter logic [`FP_DB_W-1:0] DebounceCyc = `FP_DB_W'(`FP_DEBOUNCE_CYC),
  parameter logic [`FP_PRESS_W-1:0] PowerHoldCyc = `FP_PRESS_W'(`FP_POWER_HOLD_CYC),
  parameter logic [`FP_PRESS_W-1:0] LongPressCyc = `FP_PRESS_W'(`FP_LONG_PRESS_CYC),
  parameter logic [`FP_IDLE_W-1:0] IdleCyc = `FP_IDLE_W'(`FP_IDLE_CYC),
  parameter logic [`FP_BLINK_W-1:0] BlinkCyc = `FP_BLINK_W'(`FP_BLINK_CYC)
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [3:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic powerButton,
  input wire logic trigButton,
  input wire logic trigIn,
  input wire logic defaultButton,
  input wire logic wakeIn,
  input wire logic hostLink,
  input wire logic loggingRun,
  input wire logic loggingStopping,
  input wire logic [`FP_SLOTS-1:0] slotActive,
  input wire logic [`FP_SLOTS-1:0] slotRx,
  input wire logic auxActive,
  input wire logic auxRx,
  input wire logic intAccess,
  input wire logic usbAccess,
  input wire logic supportGen,
  input wire logic serviceMode,
  input wire logic esuLinked,
  input wire logic esuUnlocked,
  output logic sleepMode,
  output logic powerOff,
  output logic wakeLocked,
  output logic startRecord,
  output logic stopRecord,
  output logic eventMark,
  output logic factoryDefault,
  output logic usbEject,
  output logic recordToExternal,
  output logic [`FP_SLOTS-1:0] slotLed,
  output logic connectLed,
  output logic loggingLed,
  output logic internalStorageLed,
  output logic externalStorageRed,
  output logic externalStorageGreen,
  output logic infoLed,
  output logic serviceLed,
  output logic usbLed,
  output logic auxLed
);

  // ========================================================================
  // parameter checks
  if (DebounceCyc == '0 || PowerHoldCyc < 2 || LongPressCyc < 2) begin : g_badShort
    $error("front_panel_control: counts too small");
  end
  if (BlinkCyc < 2 || IdleCyc < 2) begin : g_badLong
    $error("front_panel_control: timebase counts too small");
  end

  // ========================================================================
  // helpers
  function automatic logic flashOf(input logic steady, input logic [1:0] st,
                                   input logic bl);
    // steady when quiet, blinking while stretched activity lasts
    flashOf = steady & ((st == 2'h0) | bl);
  endfunction

  function automatic logic [`FP_PRESS_W-1:0] holdLimit(input int idx);
    holdLimit = (idx == 0) ? PowerHoldCyc : LongPressCyc;
  endfunction

  // ========================================================================
  // state
  fp_state_type s_q, s_d;

  always_comb begin
    logic [3:0] raw, rise, fall;
    logic [2:0] hit, shortRel;
    logic req, wrCtrl, wrCmd, tick, idleHit, goSleep;
    logic [7:0] act;
    {raw, rise, fall, hit, shortRel, req, wrCtrl, wrCmd, tick, idleHit, goSleep, act} = '0;
    s_d = s_q;

    // ======================================================================
    // synchronise and debounce; trigger input merged with its button
    s_d.sync1 = {wakeIn, defaultButton, trigIn, trigButton, powerButton};
    s_d.sync2 = s_q.sync1;
    raw = {s_q.sync2[4], s_q.sync2[3], s_q.sync2[2] | s_q.sync2[1], s_q.sync2[0]};
    for (int i = 0; i < 4; i++) begin
      if (raw[i] == s_q.db[i]) begin
        s_d.dbCnt[i] = '0;
      end else if (s_q.dbCnt[i] >= DebounceCyc - 1'b1) begin
        s_d.db[i] = raw[i];
        s_d.dbCnt[i] = '0;
      end else begin
        s_d.dbCnt[i] = s_q.dbCnt[i] + 1'b1;
      end
    end
    s_d.dbPrev = s_q.db;
    rise = s_q.db & ~s_q.dbPrev;
    fall = ~s_q.db & s_q.dbPrev;

    // press timers saturate, so the threshold fires once per press
    for (int i = 0; i < 3; i++) begin
      hit[i] = s_q.db[i] && (s_q.pressCnt[i] == holdLimit(i) - 1'b1);
      shortRel[i] = fall[i] && (s_q.pressCnt[i] < holdLimit(i));
      if (!s_q.db[i]) begin
        s_d.pressCnt[i] = '0;
      end else if (s_q.pressCnt[i] != holdLimit(i)) begin
        s_d.pressCnt[i] = s_q.pressCnt[i] + 1'b1;
      end
    end

    // ======================================================================
    // Wishbone slave, one wait state
    req = cyc_i & stb_i;
    s_d.ack = req & ~s_q.ack;
    wrCtrl = req & we_i & s_q.ack & sel_i[0] & (adr_i == `FP_ADR_CTRL);
    wrCmd = req & we_i & s_q.ack & sel_i[0] & (adr_i == `FP_ADR_CMD);
    if (req && !s_q.ack) begin
      unique case (adr_i)
        `FP_ADR_CTRL: s_d.rdData = {25'h0, s_q.errCode, 1'b0, s_q.autoOffEn, s_q.trigMode};
        `FP_ADR_STAT: s_d.rdData = {25'h0, s_q.toExternal, loggingRun, hostLink, s_q.pwr};
        default: s_d.rdData = 32'h0;
      endcase
    end
    if (wrCtrl) begin
      s_d.trigMode = dat_i[`FP_CTRL_TRIG_LSB +: 2];
      s_d.autoOffEn = dat_i[`FP_CTRL_AUTO_BIT];
      s_d.errCode = dat_i[`FP_CTRL_ERR_LSB +: 3];
    end

    // ======================================================================
    // idle and blink timebases
    if ((|slotRx) || auxRx || hostLink || s_q.pwr != PwrOn) begin
      s_d.idleCnt = '0;
    end else if (s_q.idleCnt != IdleCyc) begin
      s_d.idleCnt = s_q.idleCnt + 1'b1;
    end
    // a host session arriving on the last idle cycle still keeps the unit awake
    idleHit = s_q.autoOffEn && !hostLink && s_q.idleCnt == IdleCyc - 1'b1;
    tick = s_q.blinkCnt == BlinkCyc - 1'b1;
    s_d.blinkCnt = tick ? '0 : s_q.blinkCnt + 1'b1;
    if (tick) begin
      s_d.blink = ~s_q.blink;
      s_d.pattern = s_q.pattern + 1'b1;
    end

    // ======================================================================
    // power state
    s_d.startRec = 1'b0;
    s_d.stopRec = 1'b0;
    s_d.mark = 1'b0;
    s_d.usbEject = 1'b0;
    s_d.factoryReset = hit[2];
    unique case (s_q.pwr)
      PwrOn: begin
        if (wrCmd && dat_i[`FP_CMD_NOWAKE_BIT]) begin
          s_d.pwr = PwrOffNoWake;
        end else if (wrCmd && dat_i[`FP_CMD_OFF_BIT]) begin
          s_d.pwr = PwrOff;
        end else if (rise[0] && !hostLink) begin
          if (s_q.db[1]) begin
            s_d.pwr = PwrOff;
          end else begin
            s_d.pwrArmed = 1'b1;
          end
        end else if (s_q.pwrArmed && !hostLink && (shortRel[0] || hit[0])) begin
          goSleep = 1'b1;
        end else if (idleHit) begin
          goSleep = 1'b1;
        end
        if (goSleep) begin
          s_d.pwr = PwrSleep;
          s_d.stopRec = loggingRun;
        end
        // trigger button by state and configured action
        if (!goSleep && s_d.pwr == PwrOn) begin
          unique case (s_q.trigMode)
            `FP_TRIG_DEFAULT: begin
              if (rise[1]) begin
                s_d.trigInRec = loggingRun;
                s_d.startRec = !loggingRun;
              end
              if (s_q.trigInRec && loggingRun && shortRel[1]) begin
                s_d.mark = 1'b1;
              end
              if (s_q.trigInRec && loggingRun && hit[1]) begin
                s_d.stopRec = 1'b1;
              end
            end
            `FP_TRIG_EJECT: s_d.usbEject = rise[1];
            default: s_d.usbEject = 1'b0;
          endcase
        end
      end
      PwrSleep: begin
        if (rise[0] || rise[3] || (rise[1] && s_q.trigMode != `FP_TRIG_EJECT)) begin
          s_d.pwr = PwrOn;
        end
      end
      PwrOff: begin
        if (rise[3]) begin
          s_d.pwr = PwrOn;
        end
      end
      PwrOffNoWake: s_d.pwr = PwrOffNoWake;
      default: s_d.pwr = PwrOn;
    endcase
    if (s_d.pwr != PwrOn || !s_q.db[0]) begin
      s_d.pwrArmed = s_d.pwr == PwrOn && rise[0] && s_d.pwrArmed;
    end
    if (!s_q.db[1]) begin
      s_d.trigInRec = rise[1] ? s_d.trigInRec : 1'b0;
    end

    // ======================================================================
    // indicators; activity stretched over two blink ticks at least
    act = {usbAccess, intAccess, auxRx, slotRx};
    for (int i = 0; i < 8; i++) begin
      if (act[i]) begin
        s_d.stretch[i] = `FP_STRETCH_MAX;
      end else if (tick && s_q.stretch[i] != 2'h0) begin
        s_d.stretch[i] = s_q.stretch[i] - 2'h1;
      end
    end
    for (int i = 0; i < `FP_SLOTS; i++) begin
      s_d.slotLed[i] = flashOf(slotActive[i], s_q.stretch[i], s_q.blink);
    end
    s_d.auxLed = flashOf(auxActive, s_q.stretch[5], s_q.blink);
    s_d.intLed = (s_q.stretch[6] != 2'h0) & s_q.blink;
    s_d.usbLed = (s_q.stretch[7] != 2'h0) & s_q.blink;
    s_d.connectLed = hostLink;
    s_d.loggingLed = loggingStopping ? s_q.blink : loggingRun;
    s_d.extRedLed = esuLinked & ~esuUnlocked;
    s_d.extGreenLed = esuLinked & esuUnlocked;
    s_d.infoLed = supportGen & s_q.blink;
    // error code n shows as n flashes, then a pause
    s_d.serviceLed = serviceMode | ((s_q.pattern[3:1] < s_q.errCode) & s_q.blink);
    // unit must be released by the operator before unplugging
    s_d.toExternal = esuLinked;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_q <= '0;
      s_q.pwr <= PwrOn;
    end else begin
      s_q <= s_d;
    end
  end

  // ========================================================================
  // outputs
  assign dat_o = s_q.rdData;
  assign ack_o = s_q.ack;
  assign sleepMode = s_q.pwr == PwrSleep;
  assign powerOff = s_q.pwr == PwrOff || s_q.pwr == PwrOffNoWake;
  assign wakeLocked = s_q.pwr == PwrOffNoWake;
  assign startRecord = s_q.startRec;
  assign stopRecord = s_q.stopRec;
  assign eventMark = s_q.mark;
  assign factoryDefault = s_q.factoryReset;
  assign usbEject = s_q.usbEject;
  assign recordToExternal = s_q.toExternal;
  assign slotLed = s_q.slotLed;
  assign connectLed = s_q.connectLed;
  assign loggingLed = s_q.loggingLed;
  assign internalStorageLed = s_q.intLed;
  assign externalStorageRed = s_q.extRedLed;
  assign externalStorageGreen = s_q.extGreenLed;
  assign infoLed = s_q.infoLed;
  assign serviceLed = s_q.serviceLed;
  assign usbLed = s_q.usbLed;
  assign auxLed = s_q.auxLed;

  // ========================================================================
  // assertions
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);

  a_combo_off: assert property (
    s_q.pwr == PwrOn && s_q.db[0] && !s_q.dbPrev[0] && s_q.db[1] && !hostLink
    && !(cyc_i && stb_i && we_i && ack_o) |=> powerOff && !wakeLocked)
    else $error("combined press did not switch off");
  a_host_block: assert property (
    s_q.pwr == PwrOn && hostLink && !(cyc_i && stb_i && we_i && ack_o)
    |=> !sleepMode && !powerOff)
    else $error("power left on-state while host connected");
  a_nowake_cmd: assert property (
    s_q.pwr == PwrOn && cyc_i && stb_i && we_i && ack_o && sel_i[0]
    && adr_i == `FP_ADR_CMD && dat_i[1] |=> wakeLocked ##1 wakeLocked)
    else $error("no-wake shutdown not held");
  a_mark_short: assert property (
    s_q.pwr == PwrOn && s_q.trigMode == `FP_TRIG_DEFAULT && s_q.trigInRec
    && loggingRun && !s_q.db[1] && s_q.dbPrev[1]
    && s_q.pressCnt[1] < LongPressCyc && !s_d.stopRec |=> eventMark ##1 !eventMark)
    else $error("short press gave no single mark");
  a_long_stop: assert property (
    s_q.pwr == PwrOn && s_d.pwr == PwrOn && s_q.trigMode == `FP_TRIG_DEFAULT
    && s_q.trigInRec && loggingRun && s_q.db[1]
    && s_q.pressCnt[1] == LongPressCyc - 1'b1 |=> stopRecord && !eventMark)
    else $error("long press did not stop recording");
  a_default_hold: assert property (
    factoryDefault |-> $past(s_q.pressCnt[2]) == LongPressCyc - 1'b1 && $past(s_q.db[2]))
    else $error("defaults restored without full hold");
  a_wake_rise: assert property (
    sleepMode && s_q.db[3] && !s_q.dbPrev[3] |=> s_q.pwr == PwrOn)
    else $error("wake edge did not leave sleep");
  a_sleep_stops: assert property (
    s_q.pwr == PwrOn && s_d.pwr == PwrSleep && loggingRun |=> sleepMode && stopRecord)
    else $error("sleep entry did not stop recording");
  a_ext_colour: assert property (
    esuLinked && !esuUnlocked ##1 1'b1 |-> externalStorageRed && !externalStorageGreen)
    else $error("locked unit not shown red");
  a_bus_ack: assert property (
    cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o)
    else $error("bus answer not a single cycle");

  c_sleep: cover property (s_q.pwr == PwrOn ##1 sleepMode);
  c_mark: cover property (eventMark);
  c_long_stop: cover property (stopRecord && !sleepMode);
  c_combo_off: cover property (s_q.pwr == PwrOn ##1 powerOff);

endmodule

// ### bench/front_panel_partner.sv
/*
 * Operator side of the front panel: pushbuttons, trigger and wake inputs, and the
 * external storage unit cable. Assumes the bench calls its tasks just after a rising
 * edge of clk; pins change only by non-blocking assignment on that edge.
 */
`timescale 1ns/1ps

module front_panel_partner #(
  parameter int ReleaseHoldCyc = 25
) (
  input wire logic clk,
  output logic powerButton,
  output logic trigButton,
  output logic trigIn,
  output logic defaultButton,
  output logic wakeIn,
  output logic esuLinked,
  output logic esuUnlocked
);
  logic [4:0] pins = 5'h00;
  logic [1:0] unit = 2'h0;

  assign {wakeIn, defaultButton, trigIn, trigButton, powerButton} = pins;
  assign {esuLinked, esuUnlocked} = unit;

  // ==========================================================================
  // buttons
  task automatic press(input logic [4:0] m, input int n);
    @(posedge clk);
    pins <= pins | m;
    repeat (n) @(posedge clk);
    pins <= pins & ~m;
    // let the debouncer see the release before the next action
    repeat (15) @(posedge clk);
  endtask

  task automatic hold(input logic [4:0] m, input logic on);
    @(posedge clk);
    pins <= on ? (pins | m) : (pins & ~m);
  endtask

  // ==========================================================================
  // external storage unit
  task automatic plug();
    @(posedge clk);
    unit <= 2'h2;
  endtask

  task automatic release_unit();
    // operator holds the removal button before the unit unlocks
    repeat (ReleaseHoldCyc) @(posedge clk);
    unit <= 2'h3;
  endtask

  task automatic unplug();
    @(posedge clk);
    // the cable is pulled only once the unit shows unlocked
    if (unit[0]) begin
      unit <= 2'h0;
    end
  endtask
endmodule

// ### bench/front_panel_control_test.sv
/*
 * Self-checking bench of the front panel control block: Wishbone register tasks,
 * operator partner for the pins, pulse counters and indicator watching.
 * Assumes shortened counts given to the design as parameters.
 */
`timescale 1ns/1ps
`include "front_panel_defs.svh"
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_mismatch++; $display("ERROR %0t: got %0h expected %0h", $time, g, e); end end

module front_panel_control_test;
  import front_panel_pkg::*;
  localparam int DbC = 4;
  localparam int HoldC = 20;
  localparam int LongC = 30;
  localparam int IdleC = 200;
  localparam int Short = DbC + 8;
  localparam int Long = LongC + DbC + 20;
  localparam logic [4:0] PWR = 5'h01, TRIG = 5'h02, TIN = 5'h04, DEF = 5'h08, WAKE = 5'h10;

  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic cyc, stb, we, ack_o;
  logic [3:0] adr, sel;
  logic [31:0] dat, dat_o;
  logic hostLink, loggingRun, loggingStopping, auxActive, auxRx, intAccess, usbAccess;
  logic supportGen, serviceMode;
  logic [4:0] slotActive, slotRx, slotLed;
  logic powerButton, trigButton, trigIn, defaultButton, wakeIn, esuLinked, esuUnlocked;
  logic sleepMode, powerOff, wakeLocked, startRecord, stopRecord, eventMark, factoryDefault;
  logic usbEject, recordToExternal, connectLed, loggingLed, internalStorageLed, infoLed;
  logic externalStorageRed, externalStorageGreen, serviceLed, usbLed, auxLed;
  logic [6:0] tog, on;
  wire [6:0] ledVec = {slotLed[0], auxLed, serviceLed, loggingLed, internalStorageLed,
    usbLed, infoLed};
  int n_mismatch = 0;
  int total_checks = 0;
  int nStart = 0, nStop = 0, nMark = 0, nDef = 0, nEject = 0;

  always #20 clk = ~clk;

  initial begin
    {cyc, stb, we, adr, sel, dat} = '0;
    {hostLink, loggingRun, loggingStopping, auxActive, auxRx, intAccess, usbAccess} = '0;
    {supportGen, serviceMode, slotActive, slotRx} = '0;
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
  end

  always @(posedge clk) begin
    nStart += startRecord;
    nStop += stopRecord;
    nMark += eventMark;
    nDef += factoryDefault;
    nEject += usbEject;
  end

  front_panel_control #(.DebounceCyc(DbC), .PowerHoldCyc(HoldC), .LongPressCyc(LongC),
    .IdleCyc(IdleC), .BlinkCyc(4)) u_dut (
    .clk, .resetn, .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel),
    .dat_i(dat), .dat_o, .ack_o, .powerButton, .trigButton, .trigIn, .defaultButton,
    .wakeIn, .hostLink, .loggingRun, .loggingStopping, .slotActive, .slotRx, .auxActive,
    .auxRx, .intAccess, .usbAccess, .supportGen, .serviceMode, .esuLinked, .esuUnlocked,
    .sleepMode, .powerOff, .wakeLocked, .startRecord, .stopRecord, .eventMark,
    .factoryDefault, .usbEject, .recordToExternal, .slotLed, .connectLed, .loggingLed,
    .internalStorageLed, .externalStorageRed, .externalStorageGreen, .infoLed,
    .serviceLed, .usbLed, .auxLed);

  front_panel_partner op (.clk, .powerButton, .trigButton, .trigIn, .defaultButton,
    .wakeIn, .esuLinked, .esuUnlocked);

  // ==========================================================================
  // tasks
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d,
      input logic [3:0] s, output logic [31:0] q);
    int i;
    @(posedge clk);
    {cyc, stb, we, adr, sel, dat} <= {2'b11, w, a, s, d};
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (ack_o !== 1'b1 && i < 20);
    q = dat_o;
    {cyc, stb} <= 2'b00;
    if (ack_o !== 1'b1) begin
      n_mismatch++;
      $display("ERROR %0t: no bus answer", $time);
      close_out();
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s = 4'hF);
    logic [31:0] q;
    wb(1'b1, a, d, s, q);
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, 4'hF, q);
    `CHK(q, e)
  endtask

  task automatic watch(input int n);
    logic [6:0] prev;
    prev = ledVec;
    tog = '0;
    on = '0;
    repeat (n) begin
      @(posedge clk);
      tog = tog | (ledVec ^ prev);
      on = on | ledVec;
      prev = ledVec;
    end
  endtask

  task automatic done_test(input string name);
    $display("test %s finished", name);
  endtask

  // ==========================================================================
  // sequence
  initial begin
    repeat (12) @(posedge clk);
    rd(`FP_ADR_STAT, 32'h1);
    rd(4'hC, 32'h0);
    wr(`FP_ADR_CTRL, 32'h73, 4'h0);
    rd(`FP_ADR_CTRL, 32'h0);
    wr(`FP_ADR_CTRL, 32'h73);
    rd(`FP_ADR_CTRL, 32'h73);
    wr(`FP_ADR_CTRL, 32'h0);
    done_test("registers");
    op.press(TRIG, 2);
    `CHK(nStart, 0)
    op.press(TRIG, Short);
    `CHK(nStart, 1)
    loggingRun <= 1'b1;
    op.press(TRIG, Short);
    `CHK(nMark, 1)
    op.press(TIN, Long);
    `CHK({nStop, nMark}, {32'd1, 32'd1})
    rd(`FP_ADR_STAT, 32'h21);
    loggingRun <= 1'b0;
    wr(`FP_ADR_CTRL, 32'h1);
    op.press(TRIG, Short);
    `CHK(nStart, 1)
    wr(`FP_ADR_CTRL, 32'h0);
    op.press(DEF, Short);
    `CHK(nDef, 0)
    op.press(DEF, Long);
    `CHK(nDef, 1)
    done_test("trigger and default");
    hostLink <= 1'b1;
    op.press(PWR, Short);
    rd(`FP_ADR_STAT, 32'h11);
    `CHK(connectLed, 1'b1)
    {hostLink, loggingRun} <= 2'b01;
    op.press(PWR, Long);
    `CHK(sleepMode, 1'b1)
    `CHK(nStop, 2)
    loggingRun <= 1'b0;
    op.press(WAKE, Short);
    `CHK(sleepMode, 1'b0)
    op.press(PWR, Short);
    rd(`FP_ADR_STAT, 32'h2);
    op.press(WAKE, Short);
    wr(`FP_ADR_CTRL, 32'h3);
    op.hold(TRIG, 1'b1);
    op.press(PWR, Short);
    op.hold(TRIG, 1'b0);
    `CHK(powerOff, 1'b1)
    op.press(WAKE, Short);
    rd(`FP_ADR_STAT, 32'h1);
    wr(`FP_ADR_CMD, 32'h1);
    rd(`FP_ADR_STAT, 32'h4);
    op.press(WAKE, Short);
    wr(`FP_ADR_CMD, 32'h3);
    op.press(WAKE, Short);
    rd(`FP_ADR_STAT, 32'h8);
    `CHK(wakeLocked, 1'b1)
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    rd(`FP_ADR_STAT, 32'h1);
    wr(`FP_ADR_CTRL, 32'h4);
    repeat (IdleC + 60) @(posedge clk);
    `CHK(sleepMode, 1'b1)
    // eject mode leaves the trigger unable to wake; default mode wakes without recording
    wr(`FP_ADR_CTRL, 32'h2);
    op.press(TRIG, Short);
    `CHK(sleepMode, 1'b1)
    wr(`FP_ADR_CTRL, 32'h0);
    op.press(TRIG, Short);
    `CHK(sleepMode, 1'b0)
    `CHK(nStart, 1)
    wr(`FP_ADR_CTRL, 32'h2);
    op.press(TRIG, Short);
    `CHK({nEject, nStart}, {32'd1, 32'd1})
    wr(`FP_ADR_CTRL, 32'h0);
    done_test("power");
    {slotActive[0], auxActive, serviceMode} <= 3'b111;
    op.plug();
    repeat (3) @(posedge clk);
    watch(40);
    `CHK(tog, 7'h00)
    `CHK(on, 7'h70)
    `CHK({externalStorageRed, externalStorageGreen, recordToExternal}, 3'b101)
    rd(`FP_ADR_STAT, 32'h41);
    op.release_unit();
    repeat (3) @(posedge clk);
    `CHK({externalStorageRed, externalStorageGreen}, 2'b01)
    op.unplug();
    repeat (3) @(posedge clk);
    `CHK({externalStorageRed, externalStorageGreen}, 2'b00)
    wr(`FP_ADR_CTRL, 32'h30);
    {slotRx[0], auxRx, loggingStopping, supportGen, serviceMode, intAccess, usbAccess} <= 7'h7B;
    @(posedge clk);
    {intAccess, usbAccess} <= 2'b00;
    watch(80);
    `CHK(on, 7'h7F)
    `CHK(tog & 7'h79, 7'h79)
    done_test("indicators");
    close_out();
  end

  initial begin
    repeat (60000) @(posedge clk);
    n_mismatch++;
    $display("ERROR %0t: run too long", $time);
    close_out();
  end
endmodule
